// ==== src/dpl_power_link.sv ====
// Power modes, link enable, calibration and loopback selection
//
// What this block does
// - Reset leaves line-link powerdown set, powerdown clear.
// - Bit-clock lock is reached within one millisecond.
// - Link stays off until line-link powerdown clears.
// - Two power bits pick one of four modes.
// - Both bits clear: normal two-way link traffic.
// - Sleep keeps only link and ring detect alive.
// - Only reset leaves sleep or deep powerdown.
// - Deep powerdown: nothing works, ring detect off.
// - Off-hook or power loss runs resistor calibration.
// - ADC calibration follows resistor calibration, 256 ms.
// - Manual ADC calibration on trigger pulse, 256 ms.
// - Line-link powerdown routes receive through filters to transmit.
// - Frame detect sets once the link is up.
// - Digital loopback copies receive to transmit directly.
// - Link loopback sends receive over link and back.
// - Highway analog loopback filters line data, returns it.
// - Hybrid disabled: receive data loops through the line.
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module dpl_power_link
    import dpl_pkg::*;
#(
    parameter int LOCK_CYC = PLL_LOCK_CYC,
    parameter int RCAL_CYC_P = RCAL_CYC,
    parameter int ADC_CYC_P = ADC_CAL_CYC
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Highway pins
    input wire logic highway_bit_clock,
    input wire logic highway_frame_sync,
    input wire logic serial_rx_data_pin,
    output logic serial_tx_data_pin,
    // Isolation link to the line side
    output logic link_enable,
    output logic link_tx_data,
    input wire logic link_rx_data,
    input wire logic link_frame_in,
    input wire logic line_ring_in,
    input wire logic line_power_lost,
    // Status
    output logic ring_detect_output,
    output logic pll_locked
);
    typedef struct packed
    {
        logic [6:0] s1;
        logic [6:0] s2;
        logic bclk_q;
        logic ack;
        logic [31:0] dat;
        logic [7:0] r_link;
        logic [7:0] r_hyb;
        logic [7:0] r_hook;
        logic [7:0] r_pwr;
        logic [7:0] r_dlb;
        logic [7:0] r_cal;
        logic [7:0] r_rcal;
        logic [7:0] r_hwy;
        dpl_pm_e pm;
        dpl_cal_e cal;
        logic [24:0] cnt;
        logic hook_q;
        logic plost_q;
        logic manual_cal_trigger_q;
        logic link_frame_detect;
        logic tx;
        logic ltx;
        logic ring;
    } dpl_top_s;

    dpl_top_s q;
    dpl_top_s n;

    logic bclk_rise;
    logic filt_in;
    logic filt_out;
    logic lock;
    logic req;
    logic wr;
    logic link_on;
    logic func;
    logic cal_go;
    logic man_go;
    logic dig_lb;
    logic rx;
    logic lrx;
    logic [7:0] idx;

    function automatic logic [7:0] rd_reg(input dpl_top_s s, input logic [7:0] i,
                                          input logic lk);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            REG_LINK_LB: v = s.r_link;
            REG_HYBRID: v = s.r_hyb;
            REG_HOOK: v = s.r_hook;
            REG_POWER: v = s.r_pwr;
            REG_DIG_LB: v = s.r_dlb;
            REG_LINE_STAT: v[BIT_FRAME_DET] = s.link_frame_detect;
            REG_CAL: v = s.r_cal;
            REG_RCAL: v = s.r_rcal;
            REG_HWY: v = s.r_hwy;
            REG_SYS_STAT: v = {2'b00, s.pm, s.cal, 1'b0, lk};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : rd_reg

    function automatic dpl_pm_e pick_mode(input logic [7:0] pwr);
        dpl_pm_e m;
        m = PM_RESET;
        case ({pwr[BIT_LINE_PD], pwr[BIT_SYS_PD]})
            2'b00: m = PM_NORMAL;
            2'b01: m = PM_SLEEP;
            2'b11: m = PM_DEEP;
            default: m = PM_RESET;
        endcase
        return m;
    endfunction : pick_mode

    dpl_pll_lock #(
        .LOCK_CYC(LOCK_CYC)
    ) u_pll (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .bclk_rise(bclk_rise),
        .highway_frame_sync_lvl(q.s2[1]),
        .lock(lock)
    );

    dpl_delay_line #(
        .DEPTH(FILT_DEPTH)
    ) u_filt (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .shift(bclk_rise),
        .din(filt_in),
        .dout(filt_out)
    );

    assign bclk_rise = q.s2[0] & ~q.bclk_q;
    assign rx = q.s2[2];
    assign lrx = q.s2[3];
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & ~q.ack & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    assign link_on = (q.pm == PM_NORMAL) || (q.pm == PM_SLEEP);
    assign func = (q.pm == PM_NORMAL);
    assign dig_lb = q.r_dlb[BIT_DIG_LB];
    // Highway analog loopback feeds line data into the filters
    assign filt_in = q.r_hwy[BIT_HWY_LB] ? lrx : rx;
    assign cal_go = func && ((q.r_hook[BIT_OFF_HOOK] && !q.hook_q)
                             || (q.s2[6] && !q.plost_q));
    assign man_go = func && q.r_cal[BIT_AUTO_CAL_DIS]
                    && q.manual_cal_trigger_q && !q.r_cal[BIT_MAN_CAL];

    always_comb
    begin
        n = q;
        // Pins from outside this clock domain pass two flops first
        n.s1 = {line_power_lost, line_ring_in, link_frame_in, link_rx_data,
                serial_rx_data_pin, highway_frame_sync, highway_bit_clock};
        n.s2 = q.s1;
        n.bclk_q = q.s2[0];
        n.hook_q = q.r_hook[BIT_OFF_HOOK];
        n.plost_q = q.s2[6];
        n.manual_cal_trigger_q = q.r_cal[BIT_MAN_CAL];
        // Single-cycle ack; dropped in the cycle after it was given
        n.ack = req & ~q.ack;
        if (req && !q.ack && !wb_we_i)
        begin
            n.dat = {24'h000000, rd_reg(q, idx, lock)};
        end
        if (wr)
        begin
            case (idx)
                REG_LINK_LB: n.r_link = wb_dat_i[7:0];
                REG_HYBRID: n.r_hyb = wb_dat_i[7:0];
                REG_HOOK: n.r_hook = wb_dat_i[7:0];
                REG_POWER:
                begin
                    // Sleep and deep powerdown ignore writes; only reset leaves them
                    if (q.pm == PM_RESET || q.pm == PM_NORMAL)
                    begin
                        n.r_pwr = wb_dat_i[7:0];
                    end
                end
                REG_DIG_LB: n.r_dlb = wb_dat_i[7:0];
                REG_CAL: n.r_cal = wb_dat_i[7:0];
                REG_RCAL: n.r_rcal = wb_dat_i[7:0];
                REG_HWY: n.r_hwy = wb_dat_i[7:0];
                default: n.r_link = q.r_link;
            endcase
        end
        case (q.pm)
            PM_RESET, PM_NORMAL: n.pm = pick_mode(q.r_pwr);
            PM_SLEEP: n.pm = PM_SLEEP;
            PM_DEEP: n.pm = PM_DEEP;
            default: n.pm = PM_RESET;
        endcase
        // Frame detect: clear wins, cleared whenever the link is off
        if (!link_on)
        begin
            n.link_frame_detect = 1'b0;
        end
        else if (q.s2[4])
        begin
            n.link_frame_detect = 1'b1;
        end
        if (q.cnt != 25'h0000000)
        begin
            n.cnt = q.cnt - 25'h0000001;
        end
        case (q.cal)
            CAL_IDLE:
            begin
                if (cal_go && !q.r_rcal[BIT_RCAL_DIS])
                begin
                    n.cal = CAL_RES;
                    n.cnt = 25'(RCAL_CYC_P);
                end
                else if ((cal_go && !q.r_cal[BIT_AUTO_CAL_DIS]) || man_go)
                begin
                    n.cal = CAL_ADC;
                    n.cnt = 25'(ADC_CYC_P);
                end
            end
            CAL_RES:
            begin
                if (q.cnt == 25'h0000001)
                begin
                    n.cal = q.r_cal[BIT_AUTO_CAL_DIS] ? CAL_IDLE : CAL_ADC;
                    n.cnt = q.r_cal[BIT_AUTO_CAL_DIS] ? 25'h0000000 : 25'(ADC_CYC_P);
                end
            end
            CAL_ADC:
            begin
                if (q.cnt == 25'h0000001)
                begin
                    n.cal = CAL_IDLE;
                end
            end
            default: n.cal = CAL_IDLE;
        endcase
        // Leaving normal mode abandons a calibration on that same edge
        if (n.pm != PM_NORMAL)
        begin
            n.cal = CAL_IDLE;
            n.cnt = 25'h0000000;
        end
        n.ring = link_on && q.link_frame_detect && q.s2[5];
        if (bclk_rise)
        begin
            n.tx = 1'b0;
            n.ltx = 1'b0;
            if ((q.pm == PM_RESET || func) && dig_lb)
            begin
                n.tx = rx;
            end
            else if (q.pm == PM_RESET)
            begin
                n.tx = filt_out;
            end
            else if (func)
            begin
                n.tx = lrx;
            end
            if (func)
            begin
                // Test modes are assumed exclusive; link loopback wins here
                if (q.r_link[BIT_LINK_LB] || !q.r_hyb[BIT_HYBRID])
                begin
                    n.ltx = rx;
                end
                else
                begin
                    n.ltx = filt_out;
                end
            end
        end
        // Quiet link data from the very edge that leaves normal mode
        if (n.pm != PM_NORMAL)
        begin
            n.ltx = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            q <= '0;
            q.r_pwr <= POWER_RST;
            q.r_hyb <= HYBRID_RST;
        end
        else if (ce)
        begin
            q <= n;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign serial_tx_data_pin = q.tx;
    assign link_tx_data = q.ltx;
    assign link_enable = link_on;
    assign ring_detect_output = q.ring;
    assign pll_locked = lock;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    property p_rst_pwr;
        $fell(srst) |-> q.r_pwr[BIT_LINE_PD] && !q.r_pwr[BIT_SYS_PD];
    endproperty
    a_rst_pwr: assert property (p_rst_pwr) else $error("bad reset power");

    property p_link_off;
        q.pm == PM_RESET || q.pm == PM_DEEP |-> !link_enable && !link_tx_data;
    endproperty
    a_link_off: assert property (p_link_off) else $error("link active");

    property p_mode_sel;
        ce && q.pm == PM_RESET && q.r_pwr[BIT_LINE_PD] == 1'b0
            && q.r_pwr[BIT_SYS_PD] == 1'b0 |=> q.pm == PM_NORMAL;
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("mode wrong");

    property p_stay_down;
        q.pm == PM_SLEEP || q.pm == PM_DEEP |=> $stable(q.pm) && $stable(q.r_pwr);
    endproperty
    a_stay_down: assert property (p_stay_down) else $error("left sleep");

    property p_deep_ring;
        q.pm == PM_DEEP |-> ##1 !ring_detect_output [*3];
    endproperty
    a_deep_ring: assert property (p_deep_ring) else $error("ring in deep");

    property p_rcal;
        ce && q.cal == CAL_IDLE && cal_go && q.r_rcal[BIT_RCAL_DIS] |=> q.cal != CAL_RES;
    endproperty
    a_rcal: assert property (p_rcal) else $error("rcal not disabled");

    property p_adc_len;
        q.cal == CAL_ADC |-> q.cnt <= 25'(ADC_CYC_P) && func;
    endproperty
    a_adc_len: assert property (p_adc_len) else $error("adc cal too long");

    property p_adc_order;
        $rose(q.cal == CAL_ADC) |-> $past(q.cal) == CAL_RES
            || $past(cal_go) || $past(man_go);
    endproperty
    a_adc_order: assert property (p_adc_order) else $error("adc cal early");

    property p_startup_lb;
        ce && bclk_rise && q.pm == PM_RESET && !dig_lb |=> serial_tx_data_pin == $past(filt_out);
    endproperty
    a_startup_lb: assert property (p_startup_lb) else $error("start loop bad");

    property p_ddl;
        ce && bclk_rise && dig_lb && (q.pm == PM_RESET || func)
            |=> serial_tx_data_pin == $past(rx);
    endproperty
    a_ddl: assert property (p_ddl) else $error("data loop bad");

    property p_fdt;
        ce && !link_on |=> !q.link_frame_detect;
    endproperty
    a_fdt: assert property (p_fdt) else $error("frame detect stale");

    property p_link_lb;
        ce && bclk_rise && func && pick_mode(q.r_pwr) == PM_NORMAL && q.r_link[BIT_LINK_LB]
            |=> link_tx_data == $past(rx);
    endproperty
    a_link_lb: assert property (p_link_lb) else $error("link loop bad");

    property p_cv_sleep;
        q.pm == PM_NORMAL ##1 q.pm == PM_SLEEP;
    endproperty
    c_cv_sleep: cover property (p_cv_sleep);

    property p_cv_adc;
        q.cal == CAL_ADC ##1 q.cal == CAL_IDLE;
    endproperty
    c_cv_adc: cover property (p_cv_adc);

    property p_cv_fdt;
        $rose(q.link_frame_detect);
    endproperty
    c_cv_fdt: cover property (p_cv_fdt);
endmodule : dpl_power_link

// ==== src/dpl_pkg.sv ====
// Shared constants and types for the line-link power and test control block
package dpl_pkg;
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int PLL_LOCK_US = 1000;
    localparam int PLL_LOCK_CYC = PLL_LOCK_US * (CLK_HZ / 1_000_000);
    localparam int RCAL_MS = 17;
    localparam int RCAL_CYC = RCAL_MS * (CLK_HZ / 1000);
    localparam int ADC_CAL_MS = 256;
    localparam int ADC_CAL_CYC = ADC_CAL_MS * (CLK_HZ / 1000);
    localparam int PLL_LOCK_EDGES = 64;
    localparam int BCLK_GAP_CYC = 64;
    localparam int FILT_DEPTH = 16;
    // Register indices (byte address is four times the index)
    localparam logic [7:0] REG_LINK_LB = 8'h01;
    localparam logic [7:0] REG_HYBRID = 8'h02;
    localparam logic [7:0] REG_HOOK = 8'h05;
    localparam logic [7:0] REG_POWER = 8'h06;
    localparam logic [7:0] REG_DIG_LB = 8'h0A;
    localparam logic [7:0] REG_LINE_STAT = 8'h0C;
    localparam logic [7:0] REG_CAL = 8'h11;
    localparam logic [7:0] REG_RCAL = 8'h19;
    localparam logic [7:0] REG_HWY = 8'h21;
    localparam logic [7:0] REG_SYS_STAT = 8'h30;
    // Field positions
    localparam int BIT_LINK_LB = 1;
    localparam int BIT_HYBRID = 1;
    localparam int BIT_OFF_HOOK = 0;
    localparam int BIT_SYS_PD = 3;
    localparam int BIT_LINE_PD = 4;
    localparam int BIT_DIG_LB = 0;
    localparam int BIT_FRAME_DET = 6;
    localparam int BIT_AUTO_CAL_DIS = 5;
    localparam int BIT_MAN_CAL = 6;
    localparam int BIT_RCAL_DIS = 5;
    localparam int BIT_HWY_LB = 7;
    // Reset values
    localparam logic [7:0] POWER_RST = 8'h10;
    localparam logic [7:0] HYBRID_RST = 8'h02;
    // Power modes and calibration phases
    typedef enum logic [1:0] {PM_RESET, PM_NORMAL, PM_SLEEP, PM_DEEP} dpl_pm_e;
    typedef enum logic [1:0] {CAL_IDLE, CAL_RES, CAL_ADC} dpl_cal_e;
endpackage : dpl_pkg

// ==== src/dpl_delay_line.sv ====
// Bit-serial delay line standing in for the filter group delay
`timescale 1ns/1ps
module dpl_delay_line
    import dpl_pkg::*;
#(
    parameter int DEPTH = FILT_DEPTH
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    // Stream
    input wire logic shift,
    input wire logic din,
    output logic dout
);
    typedef struct packed
    {
        logic [DEPTH-1:0] sh;
    } dpl_dl_s;

    dpl_dl_s q;
    dpl_dl_s n;

    always_comb
    begin
        n = q;
        if (shift)
        begin
            n.sh = {q.sh[DEPTH-2:0], din};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= n;
        end
    end

    assign dout = q.sh[DEPTH-1];
endmodule : dpl_delay_line

// ==== src/dpl_pll_lock.sv ====
// Lock tracker for the highway bit clock and frame sync
`timescale 1ns/1ps
module dpl_pll_lock
    import dpl_pkg::*;
#(
    parameter int LOCK_CYC = PLL_LOCK_CYC
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    // Synchronised highway clocking
    input wire logic bclk_rise,
    input wire logic highway_frame_sync_lvl,
    // Status
    output logic lock
);
    typedef struct packed
    {
        logic [7:0] gap;
        logic [6:0] edges;
        logic [23:0] run;
        logic seen_fs;
        logic lock;
    } dpl_pll_s;

    dpl_pll_s q;
    dpl_pll_s n;

    always_comb
    begin
        n = q;
        if (bclk_rise)
        begin
            n.gap = 8'h00;
            if (q.edges != 7'(PLL_LOCK_EDGES))
            begin
                n.edges = q.edges + 7'h01;
            end
        end
        else
        begin
            n.gap = q.gap + 8'h01;
        end
        if (q.edges != 7'h00 && q.run != 24'(LOCK_CYC))
        begin
            n.run = q.run + 24'h000001;
        end
        if (highway_frame_sync_lvl)
        begin
            n.seen_fs = 1'b1;
        end
        n.lock = (q.edges == 7'(PLL_LOCK_EDGES)) && q.seen_fs;
        // Clock stopped: lock is lost and acquisition restarts
        if (q.gap == 8'(BCLK_GAP_CYC))
        begin
            n = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= n;
        end
    end

    assign lock = q.lock;

    property p_lock_time;
        @(posedge clk_sys) disable iff (srst)
        (q.run == 24'(LOCK_CYC)) && (q.gap < 8'(BCLK_GAP_CYC)) |-> q.lock;
    endproperty
    a_lock_time: assert property (p_lock_time) else $error("lock late");
endmodule : dpl_pll_lock

// ==== test/dpl_line_model.sv ====
// Behavioural line-side partner on the far end of the isolation link
`timescale 1ns/1ps
module dpl_line_model
(
    // Clock
    input wire logic clk_sys,
    // Link from the system side
    input wire logic link_enable,
    input wire logic link_tx_data,
    // Link back to the system side
    output logic link_rx_data,
    output logic link_frame_in
);
    logic [4:0] up_cnt;

    initial
    begin
        up_cnt = 5'h00;
        link_rx_data = 1'b0;
        link_frame_in = 1'b0;
    end

    // Frames only after some startup time, as a real link needs
    always @(posedge clk_sys)
    begin
        if (!link_enable)
        begin
            up_cnt <= 5'h00;
            link_frame_in <= 1'b0;
            // Released line: pattern changes every cycle
            link_rx_data <= ~link_rx_data;
        end
        else
        begin
            if (up_cnt != 5'h14)
                up_cnt <= up_cnt + 5'h01;
            link_frame_in <= (up_cnt == 5'h14);
            // Line side returns the stream it is sent
            link_rx_data <= link_tx_data;
        end
    end
endmodule : dpl_line_model

// ==== test/dpl_power_link_tb.sv ====
// Self-checking bench for the power, link and test-mode control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module dpl_power_link_tb
    import dpl_pkg::*;
;
    localparam int LOCK_T = 1000;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0, rdat;
    logic [3:0] sel = 4'h0;
    logic ack, bclk = 1'b0, frm_sync = 1'b0, rx = 1'b0, tx;
    logic link_en, link_tx, link_rx, link_frm, ring_in = 1'b0, ring_out, locked;
    logic bclk_on = 1'b0, plost = 1'b0;
    logic [2:0] ph = 3'h0;
    logic [4:0] bits = 5'h00;
    logic [7:0] q;
    int num_errors = 0;
    int checks = 0;

    dpl_power_link #(.LOCK_CYC(LOCK_T), .RCAL_CYC_P(50), .ADC_CYC_P(100)) uut (
        .clk_sys(clk_sys), .srst(srst), .ce(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .highway_bit_clock(bclk), .highway_frame_sync(frm_sync),
        .serial_rx_data_pin(rx), .serial_tx_data_pin(tx),
        .link_enable(link_en), .link_tx_data(link_tx), .link_rx_data(link_rx),
        .link_frame_in(link_frm), .line_ring_in(ring_in), .line_power_lost(plost),
        .ring_detect_output(ring_out), .pll_locked(locked));

    dpl_line_model line (.clk_sys(clk_sys), .link_enable(link_en),
        .link_tx_data(link_tx), .link_rx_data(link_rx), .link_frame_in(link_frm));

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    // Bit clock of 80 ns with a frame sync once every 32 bits
    always @(posedge clk_sys)
    begin
        if (bclk_on)
        begin
            ph <= ph + 3'h1;
            bclk <= ph[2];
            if (ph == 3'h7)
                bits <= bits + 5'h01;
            frm_sync <= (bits == 5'h00);
        end
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        forever
        begin
            @(posedge clk_sys);
            if (ack === 1'b1)
                break;
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic do_reset();
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
    endtask : do_reset

    task automatic stream(input logic v, input int n, input logic ex, input string nm);
        @(posedge clk_sys);
        rx <= v;
        repeat (n * 8) @(posedge clk_sys);
        `CHK(nm, ex, tx)
    endtask : stream

    task automatic wait_phase(input logic [1:0] ph_ex);
        int i;
        for (i = 0; i < 100; i++)
        begin
            wb(1'b0, REG_SYS_STAT, 8'h00);
            if (q[3:2] === ph_ex)
                break;
        end
        `CHK("cal phase", ph_ex, q[3:2])
    endtask : wait_phase

    task automatic t_defaults();
        wb(1'b0, REG_POWER, 8'h00);
        `CHK("power reset", POWER_RST, q)
        wb(1'b0, REG_HYBRID, 8'h00);
        `CHK("hybrid reset", HYBRID_RST, q)
        wb(1'b0, REG_SYS_STAT, 8'h00);
        `CHK("mode reset", 2'h0, q[5:4])
        `CHK("link off", 1'b0, link_en)
        wb(1'b0, 8'h3F, 8'h00);
        `CHK("unmapped", 8'h00, q)
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_lock();
        int i;
        bclk_on <= 1'b1;
        for (i = 0; i < LOCK_T && locked !== 1'b1; i++)
            @(posedge clk_sys);
        `CHK("pll lock", 1'b1, locked)
        $display("test lock done");
    endtask : t_lock

    task automatic t_loops();
        stream(1'b0, 20, 1'b0, "filter low");
        stream(1'b1, 2, 1'b0, "filter delay");
        stream(1'b1, 20, 1'b1, "filter high");
        wb(1'b1, REG_DIG_LB, 8'h01);
        stream(1'b0, 2, 1'b0, "direct low");
        stream(1'b1, 2, 1'b1, "direct high");
        wb(1'b1, REG_DIG_LB, 8'h00);
        $display("test loopbacks done");
    endtask : t_loops

    task automatic t_normal();
        wb(1'b1, REG_POWER, 8'h00);
        repeat (2) @(posedge clk_sys);
        `CHK("link on", 1'b1, link_en)
        repeat (60) @(posedge clk_sys);
        wb(1'b0, REG_LINE_STAT, 8'h00);
        `CHK("frame detect", 1'b1, q[BIT_FRAME_DET])
        wb(1'b0, REG_SYS_STAT, 8'h00);
        `CHK("mode normal", 2'h1, q[5:4])
        ring_in <= 1'b1;
        repeat (10) @(posedge clk_sys);
        `CHK("ring normal", 1'b1, ring_out)
        $display("test normal done");
    endtask : t_normal

    task automatic t_cal();
        wb(1'b1, REG_HOOK, 8'h01);
        wait_phase(2'h1);
        wait_phase(2'h2);
        wait_phase(2'h0);
        // Short high runs: the 16-bit filter path could not pass them in time
        wb(1'b1, REG_LINK_LB, 8'h02);
        stream(1'b0, 24, 1'b0, "link loop low");
        stream(1'b1, 6, 1'b1, "link loop high");
        wb(1'b1, REG_LINK_LB, 8'h00);
        wb(1'b1, REG_HYBRID, 8'h00);
        stream(1'b0, 24, 1'b0, "hybrid off low");
        stream(1'b1, 6, 1'b1, "hybrid off high");
        wb(1'b1, REG_HYBRID, HYBRID_RST);
        wb(1'b1, REG_RCAL, 8'h20);
        wb(1'b1, REG_CAL, 8'h20);
        wb(1'b1, REG_CAL, 8'h60);
        wb(1'b1, REG_CAL, 8'h20);
        wait_phase(2'h2);
        wait_phase(2'h0);
        wb(1'b1, REG_CAL, 8'h00);
        plost <= 1'b1;
        wait_phase(2'h2);
        wait_phase(2'h0);
        plost <= 1'b0;
        wb(1'b1, REG_RCAL, 8'h00);
        plost <= 1'b1;
        wait_phase(2'h1);
        wait_phase(2'h2);
        wait_phase(2'h0);
        $display("test calibration done");
    endtask : t_cal

    task automatic t_sleep();
        wb(1'b1, REG_POWER, 8'h08);
        repeat (10) @(posedge clk_sys);
        wb(1'b0, REG_SYS_STAT, 8'h00);
        `CHK("mode sleep", 2'h2, q[5:4])
        `CHK("sleep link", 1'b1, link_en)
        `CHK("sleep ring", 1'b1, ring_out)
        wb(1'b1, REG_POWER, 8'h00);
        wb(1'b0, REG_SYS_STAT, 8'h00);
        `CHK("sleep held", 2'h2, q[5:4])
        do_reset();
        wb(1'b0, REG_POWER, 8'h00);
        `CHK("power after wake", POWER_RST, q)
        $display("test sleep done");
    endtask : t_sleep

    task automatic t_deep();
        wb(1'b1, REG_POWER, 8'h18);
        repeat (10) @(posedge clk_sys);
        wb(1'b0, REG_SYS_STAT, 8'h00);
        `CHK("mode deep", 2'h3, q[5:4])
        `CHK("deep link", 1'b0, link_en)
        `CHK("deep ring", 1'b0, ring_out)
        do_reset();
        wb(1'b0, REG_SYS_STAT, 8'h00);
        `CHK("mode after deep", 2'h0, q[5:4])
        $display("test deep done");
    endtask : t_deep

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        close_out();
    end

    initial
    begin
        do_reset();
        t_defaults();
        t_lock();
        t_loops();
        t_normal();
        t_cal();
        t_sleep();
        t_deep();
        close_out();
    end
endmodule : dpl_power_link_tb
